/* common/dcs_regs.vh */
// Constants for the dual-channel serial slave front-end
// Functional notes
// - First block serves own axis, even addresses
// - Second block serves own axis, odd addresses
// - Both blocks look like one slave
// - Each block keeps its own shift register
// - Compare both shift registers at frame end
// - Mismatch: second silent, first replies error
// - Match: decode, addressed block replies next frame
// - Clock idle low, sample first edge, MSB first
// - Reply shifts out only in following transfer
// - Ignore clock and data while deselected
// - Pending reply survives traffic to other slaves
// - Valid commands: register access, acceleration request
// - Initialise after power-up, undervoltage, reset command
`ifndef DCS_REGS_VH
`define DCS_REGS_VH

// Message geometry
`define DCS_MSG_BITS      16
`define DCS_CNT_BITS      5
`define DCS_TYPE_HI       15
`define DCS_TYPE_LO       14
`define DCS_ACC_AXIS_BIT  13
`define DCS_ADDR_HI       13
`define DCS_ADDR_LO       8
`define DCS_DATA_HI       7
`define DCS_DATA_LO       0

// Command type codes in bits 15:14
`define DCS_CMD_NONE      2'b00
`define DCS_CMD_ACC       2'b01
`define DCS_CMD_REG_RD    2'b10
`define DCS_CMD_REG_WR    2'b11

// Reply headers in bits 15:14
`define DCS_RSP_ACC       2'b01
`define DCS_RSP_REG       2'b10
`define DCS_RSP_ERR_WORD  16'hc000

// Serial reset sequence: two writes to one address
`define DCS_RST_ADDR      6'h3e
`define DCS_RST_KEY1      8'ha5
`define DCS_RST_KEY2      8'h5a

// Register reset value
`define DCS_REG_RESET     8'h00

// Initialisation time
`define DCS_INIT_NS       2000
`define DCS_CLK_NS        5
`define DCS_INIT_CYCLES   ((`DCS_INIT_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)

`endif

/* design/dcs_axis_block.v */
// One axis interface block: shift register, decoder, registers, reply
`timescale 1ns/1ps
`include "dcs_regs.vh"

module dcs_axis_block #(
    parameter       AXIS_ID   = 0,
    parameter       ACC_BITS  = 10,
    parameter       REG_DEPTH = 32
) (
    input  wire                     clk,
    input  wire                     reset,
    input  wire                     init,
    input  wire                     shift_en,
    input  wire                     shift_bit,
    input  wire                     decode,
    input  wire                     match,
    input  wire [ACC_BITS-1:0]      acc_data,
    output wire [`DCS_MSG_BITS-1:0] rx_word,
    output reg                      reply_vld_r,
    output reg  [`DCS_MSG_BITS-1:0] reply_r
);
    reg  [`DCS_MSG_BITS-1:0] shreg_r;
    reg  [7:0]               regs_r [0:REG_DEPTH-1];
    wire [1:0]               cmd_type;
    wire [5:0]               addr;
    wire [4:0]               idx;
    wire                     acc_mine;
    wire                     reg_mine;
    wire                     wr_en;

    assign rx_word  = shreg_r;
    assign cmd_type = shreg_r[`DCS_TYPE_HI:`DCS_TYPE_LO];
    assign addr     = shreg_r[`DCS_ADDR_HI:`DCS_ADDR_LO];
    assign idx      = addr[5:1];
    // Own-axis acceleration and own-parity register commands only
    assign acc_mine = (cmd_type == `DCS_CMD_ACC) &&
                      (shreg_r[`DCS_ACC_AXIS_BIT] == AXIS_ID);
    assign reg_mine = cmd_type[1] && (addr[0] == AXIS_ID);
    assign wr_en    = decode && match && reg_mine &&
                      (cmd_type == `DCS_CMD_REG_WR);

    // Private copy of every frame, no sharing with the other axis
    always @(posedge clk) begin
        if (reset || init)
            shreg_r <= {`DCS_MSG_BITS{1'b0}};
        else if (shift_en)
            shreg_r <= {shreg_r[`DCS_MSG_BITS-2:0], shift_bit};
    end

    genvar g;
    generate
        for (g = 0; g < REG_DEPTH; g = g + 1) begin : g_reg
            always @(posedge clk) begin
                if (reset || init)
                    regs_r[g] <= `DCS_REG_RESET;
                else if (wr_en && (idx == g))
                    regs_r[g] <= shreg_r[`DCS_DATA_HI:`DCS_DATA_LO];
            end
        end
    endgenerate

    // Reply is held until the next decoded frame, whatever else the bus does
    always @(posedge clk) begin
        if (reset || init) begin
            reply_vld_r <= 1'b0;
            reply_r     <= {`DCS_MSG_BITS{1'b0}};
        end else if (decode) begin
            if (!match) begin
                reply_vld_r <= (AXIS_ID == 0);
                reply_r     <= `DCS_RSP_ERR_WORD;
            end else if (acc_mine) begin
                reply_vld_r <= 1'b1;
                reply_r     <= {`DCS_RSP_ACC, AXIS_ID[0],
                                {(13-ACC_BITS){1'b0}}, acc_data};
            end else if (reg_mine) begin
                reply_vld_r <= 1'b1;
                reply_r     <= {`DCS_RSP_REG, addr, regs_r[idx]};
            end else begin
                reply_vld_r <= 1'b0;
                reply_r     <= {`DCS_MSG_BITS{1'b0}};
            end
        end
    end
endmodule

/* design/dcs_spi_slave.v */
// Dual-channel serial slave: pin sync, framing, compare, reply, init
`timescale 1ns/1ps
`include "dcs_regs.vh"

module dcs_spi_slave #(
    parameter       ACC_BITS    = 10,
    parameter       REG_DEPTH   = 32,
    parameter       INIT_CYCLES = `DCS_INIT_CYCLES
) (
    input  wire                clk,
    input  wire                reset,
    input  wire                sclk,
    input  wire                cs_n,
    input  wire                mosi,
    input  wire                uv_reset,
    input  wire [ACC_BITS-1:0] acc_x,
    input  wire [ACC_BITS-1:0] acc_y,
    output wire                miso_o,
    output reg                 miso_oe_r,
    output reg                 init_busy_r
);
    localparam [2:0] ST_INIT  = 3'b001;
    localparam [2:0] ST_IDLE  = 3'b010;
    localparam [2:0] ST_FRAME = 3'b100;
    localparam [15:0] INIT_LAST = INIT_CYCLES[15:0] - 16'h0001;

    // Two-stage synchronisers; sclk and cs_n get one more history stage for edge finding
    reg  [2:0]               sclk_s_r;
    reg  [2:0]               cs_s_r;
    reg  [1:0]               mosi_s_r;
    reg  [1:0]               uv_s_r;

    reg  [2:0]               state_r;
    reg  [2:0]               state_nxt;
    reg  [15:0]              init_cnt_r;
    reg  [`DCS_CNT_BITS-1:0] bit_cnt_r;
    reg  [`DCS_MSG_BITS-1:0] tx_r;
    reg                      decode_r;
    reg                      match_r;
    reg                      rst_armed_r;
    reg                      rst_cmd_r;

    wire                     sclk_rise;
    wire                     sclk_fall;
    wire                     cs_fall;
    wire                     cs_rise;
    wire                     in_frame;
    wire                     shift_en;
    wire                     init_go;
    wire [`DCS_MSG_BITS-1:0] rx_x;
    wire [`DCS_MSG_BITS-1:0] rx_y;
    wire                     vld_x;
    wire                     vld_y;
    wire [`DCS_MSG_BITS-1:0] rsp_x;
    wire [`DCS_MSG_BITS-1:0] rsp_y;
    wire                     frame_ok;
    wire                     is_rst_wr;

    always @(posedge clk) begin
        if (reset) begin
            // Idle levels, so no false edge right after reset
            sclk_s_r <= 3'b000;
            cs_s_r   <= 3'b111;
            mosi_s_r <= 2'b00;
            uv_s_r   <= 2'b00;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], sclk};
            cs_s_r   <= {cs_s_r[1:0], cs_n};
            mosi_s_r <= {mosi_s_r[0], mosi};
            uv_s_r   <= {uv_s_r[0], uv_reset};
        end
    end

    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
    assign cs_fall   = ~cs_s_r[1] & cs_s_r[2];
    assign cs_rise   = cs_s_r[1] & ~cs_s_r[2];
    assign in_frame  = (state_r == ST_FRAME);
    // Clock edges count only inside a selected frame
    assign shift_en  = in_frame && !cs_s_r[1] && sclk_rise;

    // Power-up, undervoltage or serial reset all restart init
    assign init_go   = uv_s_r[1] | rst_cmd_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_INIT: begin
                if (init_cnt_r == INIT_LAST)
                    state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                if (cs_fall)
                    state_nxt = ST_FRAME;
            end
            ST_FRAME: begin
                if (cs_rise)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_INIT;
        endcase
        if (init_go)
            state_nxt = ST_INIT;
    end

    always @(posedge clk) begin
        if (reset) begin
            state_r     <= ST_INIT;
            init_cnt_r  <= 16'h0000;
            init_busy_r <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            init_busy_r <= (state_nxt == ST_INIT);
            // A held undervoltage keeps the count at zero
            if (init_go || state_nxt != ST_INIT || state_r != ST_INIT)
                init_cnt_r <= 16'h0000;
            else
                init_cnt_r <= init_cnt_r + 16'h0001;
        end
    end

    // Bit counter: a frame of the wrong length is treated as corrupt
    // Saturates, so an overlong frame never wraps back to 16
    always @(posedge clk) begin
        if (reset || state_r == ST_INIT)
            bit_cnt_r <= {`DCS_CNT_BITS{1'b0}};
        else if (state_r == ST_IDLE && cs_fall)
            bit_cnt_r <= {`DCS_CNT_BITS{1'b0}};
        else if (shift_en && bit_cnt_r != {`DCS_CNT_BITS{1'b1}})
            bit_cnt_r <= bit_cnt_r + {{(`DCS_CNT_BITS-1){1'b0}}, 1'b1};
    end

    assign frame_ok = (bit_cnt_r == `DCS_MSG_BITS);

    // Compare both copies at deselect, decode one cycle later
    // Both copies are frozen here: the frame has ended
    always @(posedge clk) begin
        if (reset || state_r == ST_INIT) begin
            decode_r <= 1'b0;
            match_r  <= 1'b0;
        end else begin
            decode_r <= in_frame && cs_rise;
            match_r  <= (rx_x == rx_y) && frame_ok;
        end
    end

    dcs_axis_block #(
        .AXIS_ID   (0),
        .ACC_BITS  (ACC_BITS),
        .REG_DEPTH (REG_DEPTH)
    ) u_axis_x (
        .clk         (clk),
        .reset       (reset),
        .init        (init_busy_r),
        .shift_en    (shift_en),
        .shift_bit   (mosi_s_r[1]),
        .decode      (decode_r),
        .match       (match_r),
        .acc_data    (acc_x),
        .rx_word     (rx_x),
        .reply_vld_r (vld_x),
        .reply_r     (rsp_x)
    );

    dcs_axis_block #(
        .AXIS_ID   (1),
        .ACC_BITS  (ACC_BITS),
        .REG_DEPTH (REG_DEPTH)
    ) u_axis_y (
        .clk         (clk),
        .reset       (reset),
        .init        (init_busy_r),
        .shift_en    (shift_en),
        .shift_bit   (mosi_s_r[1]),
        .decode      (decode_r),
        .match       (match_r),
        .acc_data    (acc_y),
        .rx_word     (rx_y),
        .reply_vld_r (vld_y),
        .reply_r     (rsp_y)
    );

    // Serial reset: key1 then key2 in back-to-back matched frames
    assign is_rst_wr = decode_r && match_r &&
                       rx_x[`DCS_TYPE_HI:`DCS_TYPE_LO] == `DCS_CMD_REG_WR &&
                       rx_x[`DCS_ADDR_HI:`DCS_ADDR_LO] == `DCS_RST_ADDR;

    always @(posedge clk) begin
        if (reset || state_r == ST_INIT) begin
            rst_armed_r <= 1'b0;
            rst_cmd_r   <= 1'b0;
        end else begin
            rst_cmd_r <= 1'b0;
            if (decode_r) begin
                rst_armed_r <= is_rst_wr &&
                    rx_x[`DCS_DATA_HI:`DCS_DATA_LO] == `DCS_RST_KEY1;
                rst_cmd_r   <= is_rst_wr && rst_armed_r &&
                    rx_x[`DCS_DATA_HI:`DCS_DATA_LO] == `DCS_RST_KEY2;
            end
        end
    end

    // One output path: the owning block's reply is loaded at select.
    // The reply of the previous frame goes out now, never the current one.
    // Init drops the line at once, even in the middle of a frame
    always @(posedge clk) begin
        if (reset || init_go || state_r == ST_INIT) begin
            tx_r      <= {`DCS_MSG_BITS{1'b0}};
            miso_oe_r <= 1'b0;
        end else if (state_r == ST_IDLE && cs_fall) begin
            tx_r      <= vld_x ? rsp_x : rsp_y;
            miso_oe_r <= vld_x | vld_y;
        end else if (in_frame && cs_rise) begin
            miso_oe_r <= 1'b0;
        end else if (in_frame && !cs_s_r[1] && sclk_fall) begin
            tx_r      <= {tx_r[`DCS_MSG_BITS-2:0], 1'b0};
        end
    end

    // Line keeps its last bit when released; only the enable tells
    assign miso_o = tx_r[`DCS_MSG_BITS-1];
endmodule

/* sim/dcs_spi_props.sv */
// Port checker for the dual-channel serial slave
`timescale 1ns/1ps
module dcs_spi_props #(
    parameter ACC_BITS    = 10,
    parameter INIT_CYCLES = 400
) (
    input wire                clk,
    input wire                reset,
    input wire                sclk,
    input wire                cs_n,
    input wire                mosi,
    input wire                uv_reset,
    input wire [ACC_BITS-1:0] acc_x,
    input wire [ACC_BITS-1:0] acc_y,
    input wire                miso_o,
    input wire                miso_oe_r,
    input wire                init_busy_r
);
    reg [15:0] busy_cnt_r;
    always @(posedge clk) begin
        if (reset || uv_reset || !init_busy_r)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    init_after_reset_a: assert property (
        $fell(reset) |-> init_busy_r && !miso_oe_r) else $error("no init");
    init_max_a: assert property (
        busy_cnt_r <= INIT_CYCLES + 4) else $error("init too long");
    init_min_a: assert property (
        $fell(init_busy_r) |-> busy_cnt_r >= INIT_CYCLES - 1)
        else $error("init too short");
    uv_init_a: assert property (
        uv_reset [*5] |-> init_busy_r) else $error("uv without init");
    busy_quiet_a: assert property (
        init_busy_r |-> !miso_oe_r) else $error("drive during init");
    idle_quiet_a: assert property (
        cs_n [*6] |-> !miso_oe_r) else $error("drive while deselected");
    oe_late_a: assert property (
        $fell(cs_n) |-> !miso_oe_r ##1 !miso_oe_r) else $error("early drive");
    oe_hold_a: assert property (
        miso_oe_r && !cs_n |=> miso_oe_r) else $error("drive dropped");
    oe_release_a: assert property (
        $rose(cs_n) |-> ##[1:6] !miso_oe_r) else $error("drive kept");
    bit_hold_a: assert property (
        (miso_oe_r && sclk) [*5] |-> $stable(miso_o))
        else $error("data moved while clock high");
    cover property ($rose(miso_oe_r));
    cover property ($fell(init_busy_r));
    cover property (uv_reset [*5]);
endmodule
bind dcs_spi_slave dcs_spi_props #(.ACC_BITS(ACC_BITS),
    .INIT_CYCLES(INIT_CYCLES)) props_u (.clk(clk), .reset(reset),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .uv_reset(uv_reset),
    .acc_x(acc_x), .acc_y(acc_y), .miso_o(miso_o),
    .miso_oe_r(miso_oe_r), .init_busy_r(init_busy_r));

/* sim/dcs_spi_master.sv */
// Behavioural SPI master on the far side of the slave
`timescale 1ns/1ps
module dcs_spi_master (
    input  wire miso_o,
    input  wire miso_oe_r,
    output reg  sclk,
    output reg  cs_n,
    output reg  mosi
);
    // Undriven line reads as a changing pattern, never a stale bit
    wire miso_line = miso_oe_r ? miso_o : ~mosi;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Idle low, both ends sample on the rise, top bit first
    task xfer(input [15:0] w, input integer n, output [15:0] rsp,
              output oe_seen);
        integer i;
        begin
            rsp = 16'h0000;
            oe_seen = 1'b0;
            #1 cs_n = 1'b0;
            #64;
            for (i = 15; i > 15 - n; i = i - 1) begin
                mosi = w[i];
                #32 sclk = 1'b1;
                rsp = {rsp[14:0], miso_line};
                oe_seen = oe_seen | miso_oe_r;
                #32 sclk = 1'b0;
            end
            #32 cs_n = 1'b1;
            #64;
        end
    endtask
    // Traffic to another slave: clock and data move, select stays high
    task other;
        integer i;
        integer r;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                r = $urandom;
                #32 mosi = r[0];
                sclk = 1'b1;
                #32 sclk = 1'b0;
            end
        end
    endtask
endmodule

/* sim/tb.sv */
// Self-checking bench for the dual-channel serial slave
`timescale 1ns/1ps
`include "dcs_regs.vh"
module tb;
    localparam INIT_N = 40;
    reg        clk = 1'b0;
    reg        reset = 1'b1;
    reg        uv_reset = 1'b0;
    reg  [9:0] acc_x = 10'h000;
    reg  [9:0] acc_y = 10'h000;
    wire       sclk, cs_n, mosi, miso_o, miso_oe_r, init_busy_r;
    integer    fail_count = 0;
    integer    cmp_count = 0;
    integer    i, n;
    reg  [7:0] regs [0:63];
    reg [15:0] exp_w, rsp, c;
    reg        exp_v, oe;
    always #2.5 clk = ~clk;
    dcs_spi_slave #(.INIT_CYCLES(INIT_N)) dut_u (.clk(clk), .reset(reset),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .uv_reset(uv_reset),
        .acc_x(acc_x), .acc_y(acc_y), .miso_o(miso_o),
        .miso_oe_r(miso_oe_r), .init_busy_r(init_busy_r));
    dcs_spi_master master_u (.miso_o(miso_o), .miso_oe_r(miso_oe_r),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    task finish_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task cmp16(input [15:0] got, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    function [15:0] mk(input [1:0] t, input [5:0] a, input [7:0] d);
        mk = {t, a, d};
    endfunction
    function [16:0] expect_of(input [15:0] w);
        case (w[15:14])
            `DCS_CMD_ACC: expect_of = {1'b1, `DCS_RSP_ACC, w[13], 3'b000,
                                       w[13] ? acc_y : acc_x};
            `DCS_CMD_NONE: expect_of = 17'h0_0000;
            default: expect_of = {1'b1, `DCS_RSP_REG, w[13:8], regs[w[13:8]]};
        endcase
    endfunction
    task clear_model;
        integer j;
        begin
            for (j = 0; j < 64; j = j + 1)
                regs[j] = `DCS_REG_RESET;
            exp_v = 1'b0;
            exp_w = 16'h0000;
        end
    endtask
    task wait_init;
        integer k;
        begin
            cmp16({15'h0000, init_busy_r}, 16'h0001);
            k = 0;
            while (init_busy_r !== 1'b0 && k < 1000) begin
                @(negedge clk);
                k = k + 1;
            end
            cmp16({15'h0000, init_busy_r}, 16'h0000);
            clear_model;
        end
    endtask
    // Reply of the previous frame is checked, this frame's is predicted
    task frame(input [15:0] w, input integer len);
        integer r;
        begin
            @(posedge clk);
            r = $urandom;
            acc_x <= r[9:0];
            acc_y <= r[25:16];
            master_u.xfer(w, len, rsp, oe);
            cmp16({15'h0000, oe}, {15'h0000, exp_v});
            if (exp_v) cmp16(rsp, exp_w >> (16 - len));
            {exp_v, exp_w} = (len == 16) ? expect_of(w)
                                         : {1'b1, `DCS_RSP_ERR_WORD};
            if (len == 16 && w[15:14] == `DCS_CMD_REG_WR)
                regs[w[13:8]] = w[7:0];
        end
    endtask
    initial begin
        n = $urandom(66031);
        clear_model;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        wait_init;
        frame(mk(2'h3, 6'h02, 8'h5a), 16);
        frame(mk(2'h3, 6'h03, 8'ha5), 16);
        frame(mk(2'h2, 6'h02, 8'h00), 16);
        frame(mk(2'h2, 6'h03, 8'h00), 16);
        frame(mk(2'h1, 6'h00, 8'h00), 16);
        frame(mk(2'h1, 6'h20, 8'h00), 16);
        frame(mk(2'h0, 6'h02, 8'h00), 16);
        frame(mk(2'h3, 6'h02, 8'hff), 15);
        frame(mk(2'h2, 6'h02, 8'h00), 16);
        for (i = 0; i < 60; i = i + 1) begin
            n = $urandom;
            c = n[15:0];
            if (c[13:8] == `DCS_RST_ADDR) c[13:8] = 6'h3c;
            if (n[17:16] == 2'h0) master_u.other;
            frame(c, (n[20:18] == 3'h0) ? 15 : 16);
        end
        frame(mk(2'h3, `DCS_RST_ADDR, `DCS_RST_KEY1), 16);
        frame(mk(2'h3, `DCS_RST_ADDR, `DCS_RST_KEY2), 16);
        wait_init;
        frame(mk(2'h2, 6'h02, 8'h00), 16);
        frame(mk(2'h3, 6'h03, 8'h77), 16);
        @(posedge clk);
        uv_reset <= 1'b1;
        repeat (6) @(posedge clk);
        uv_reset <= 1'b0;
        wait_init;
        frame(mk(2'h2, 6'h03, 8'h00), 16);
        frame(mk(2'h2, 6'h02, 8'h00), 16);
        finish_test;
    end
    initial begin
        #300000;
        fail_count = fail_count + 1;
        finish_test;
    end
endmodule
